// file: dps_mem_peer.sv
// slot receiver model that can stall and records every slot taken
`include "dps_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dps_mem_peer import dps_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic mem_valid,
  input wire logic mem_edge_fall,
  input wire dps_cmd_t mem_cmd,
  input wire logic [`DPS_ADDR_W-1:0] mem_location,
  output logic mem_ready
);
  logic [1:0] cnt_q;
  dps_slot_t got[$];
  // two cycles taking, two refusing: long enough to fill the buffer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      mem_ready <= 1'h1;
      got.delete();
    end else begin
      cnt_q <= cnt_q + 2'h1;
      mem_ready <= !stall || cnt_q[1];
      if (mem_valid && mem_ready) got.push_back({mem_edge_fall, mem_cmd, mem_location});
    end
  end
endmodule // dps_mem_peer
`default_nettype wire

// file: dps_pkg.sv
// types of the dual-port command scheduler
`default_nettype none
`include "dps_regs.svh"
package dps_pkg;
  typedef enum logic [1:0] {
    DPS_CMD_NOP = 2'h0,
    DPS_CMD_RSVD = 2'h1,
    DPS_CMD_RD = 2'h2,
    DPS_CMD_WR = 2'h3
  } dps_cmd_t;
  typedef enum logic [1:0] {DPS_DIR_IDLE, DPS_DIR_RD, DPS_DIR_WR} dps_dir_t;
  typedef dps_cmd_t [`DPS_CH_NUM-1:0] dps_cmd_set_t;
  typedef logic [`DPS_CH_NUM-1:0][`DPS_ADDR_W-1:0] dps_addr_set_t;
  typedef struct packed {
    logic edge_fall;
    dps_cmd_t cmd;
    logic [`DPS_ADDR_W-1:0] addr;
  } dps_slot_t;
endpackage
`default_nettype wire

// file: dps_regs.svh
// constants of the dual-port command scheduler
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH
`define DPS_CH_NUM 4
`define DPS_ADDR_W 21
`define DPS_BANK_W 3
`define DPS_NOP_W 4
`define DPS_RD2WR_NOPS 4'h8
`define DPS_WR2RD_NOPS 4'h4
`define DPS_COLL_NOPS 4'h4
`define DPS_EDGE_RISE 1'b0
`define DPS_EDGE_FALL 1'b1
`endif

// file: dps_sched.sv
// dual-port four-lane command scheduler toward the memory command slots
`include "dps_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dps_sched (
  input wire logic clk,
  input wire logic rst,
  input wire logic port_a_en,
  input wire dps_pkg::dps_cmd_set_t port_a_cmd,
  input wire dps_pkg::dps_addr_set_t port_a_location,
  output logic port_a_ready,
  input wire logic port_b_en,
  input wire dps_pkg::dps_cmd_set_t port_b_cmd,
  input wire dps_pkg::dps_addr_set_t port_b_location,
  output logic port_b_ready,
  output logic mem_valid,
  output logic mem_edge_fall,
  output dps_pkg::dps_cmd_t mem_cmd,
  output logic [`DPS_ADDR_W-1:0] mem_location,
  input wire logic mem_ready
);
  import dps_pkg::*;

  dps_slot_if slot ();

  logic [1:0] en;
  dps_cmd_set_t new_cmd [2];
  dps_addr_set_t new_addr [2];
  logic [1:0] acc;
  logic [1:0] act_d;
  logic [1:0] act_q;
  logic [1:0] rdy_q;
  logic [1:0] idx_q [2];
  logic [`DPS_NOP_W-1:0] nop_q [2];
  dps_dir_t dir_q [2];
  dps_cmd_set_t cmd_q [2];
  dps_addr_set_t addr_q [2];
  logic turn_q;
  logic fair_q;
  logic fire;
  logic [`DPS_CH_NUM-1:0] hit_new;
  logic [`DPS_CH_NUM-1:0] hit_late;
  logic coll_new;
  logic coll_late;
  logic [`DPS_NOP_W-1:0] load_nop [2];
  dps_slot_t emit [2];
  logic [1:0] my_fire;
  logic [1:0] step_adv;
  logic [1:0] step_dec;
  logic [1:0] step_turn;
  logic [`DPS_NOP_W-1:0] turn_nop [2];
  dps_dir_t turn_dir [2];

  assign en = {port_b_en, port_a_en};
  assign new_cmd[0] = port_a_cmd;
  assign new_cmd[1] = port_b_cmd;
  assign new_addr[0] = port_a_location;
  assign new_addr[1] = port_b_location;
  assign acc = en & rdy_q;
  assign port_a_ready = rdy_q[0];
  assign port_b_ready = rdy_q[1];

  // lane-wise bank compare; a no-op lane touches no bank
  for (genvar c = 0; c < `DPS_CH_NUM; c++) begin : g_lane
    logic a_use;
    logic b_use;
    logic bh_use;
    assign a_use = (port_a_cmd[c] == DPS_CMD_RD) || (port_a_cmd[c] == DPS_CMD_WR);
    assign b_use = (port_b_cmd[c] == DPS_CMD_RD) || (port_b_cmd[c] == DPS_CMD_WR);
    assign bh_use = (cmd_q[1][c] == DPS_CMD_RD) || (cmd_q[1][c] == DPS_CMD_WR);
    assign hit_new[c] = a_use && b_use &&
      (port_a_location[c][`DPS_BANK_W-1:0] == port_b_location[c][`DPS_BANK_W-1:0]);
    assign hit_late[c] = a_use && bh_use &&
      (port_a_location[c][`DPS_BANK_W-1:0] == addr_q[1][c][`DPS_BANK_W-1:0]);
  end

  assign coll_new = acc[0] && acc[1] && (|hit_new);
  // fairness: once B has been postponed, A yields to the held B set when its new set hits a bank held by B
  assign coll_late = fair_q && acc[0] && act_q[1] && (|hit_late);
  assign load_nop[0] = coll_late ? `DPS_COLL_NOPS : '0;
  assign load_nop[1] = coll_new ? `DPS_COLL_NOPS : '0;

  // slots alternate A/B; a port with nothing to send fills its slot with a no-op
  assign slot.in_valid = |act_q;
  assign slot.in_slot = emit[turn_q];
  assign fire = slot.in_valid && slot.in_ready;

  for (genvar p = 0; p < 2; p++) begin : g_port
    dps_cmd_t cur;
    dps_slot_t em;
    logic s_adv;
    logic s_dec;
    logic s_turn;
    logic [`DPS_NOP_W-1:0] t_nop;
    dps_dir_t t_dir;
    logic a_nxt;
    assign cur = cmd_q[p][idx_q[p]];
    assign my_fire[p] = fire && (turn_q == 1'(p));
    // locals keep each combinational process the only writer of what it computes
    assign emit[p] = em;
    assign step_adv[p] = s_adv;
    assign step_dec[p] = s_dec;
    assign step_turn[p] = s_turn;
    assign turn_nop[p] = t_nop;
    assign turn_dir[p] = t_dir;
    assign act_d[p] = a_nxt;

    always_comb begin
      em.edge_fall = (p == 1) ? `DPS_EDGE_FALL : `DPS_EDGE_RISE;
      em.cmd = DPS_CMD_NOP;
      em.addr = '0;
      s_adv = 1'b0;
      s_dec = 1'b0;
      s_turn = 1'b0;
      t_nop = '0;
      t_dir = dir_q[p];
      if (act_q[p]) begin
        if (nop_q[p] != '0) begin
          s_dec = 1'b1;
        end else if (cur == DPS_CMD_WR && dir_q[p] == DPS_DIR_RD) begin
          s_turn = 1'b1;
          t_nop = `DPS_RD2WR_NOPS - 4'h1;
          t_dir = DPS_DIR_WR;
        end else if (cur == DPS_CMD_RD && dir_q[p] == DPS_DIR_WR) begin
          s_turn = 1'b1;
          t_nop = `DPS_WR2RD_NOPS - 4'h1;
          t_dir = DPS_DIR_RD;
        end else begin
          s_adv = 1'b1;
          // the reserved code is never sent; it goes out as a no-op
          if (cur == DPS_CMD_RD || cur == DPS_CMD_WR) begin
            em.cmd = cur;
            em.addr = addr_q[p][idx_q[p]];
            t_dir = (cur == DPS_CMD_WR) ? DPS_DIR_WR : DPS_DIR_RD;
          end
        end
      end
    end

    always_comb begin
      a_nxt = act_q[p];
      if (my_fire[p] && s_adv && idx_q[p] == 2'h3) begin
        a_nxt = 1'b0;
      end
      if (acc[p]) begin
        a_nxt = 1'b1;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        act_q[p] <= 1'b0;
        rdy_q[p] <= 1'b1;
      end else begin
        act_q[p] <= act_d[p];
        rdy_q[p] <= ~act_d[p];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cmd_q[p] <= '{default: DPS_CMD_NOP};
        addr_q[p] <= '0;
      end else if (acc[p]) begin
        cmd_q[p] <= new_cmd[p];
        addr_q[p] <= new_addr[p];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        idx_q[p] <= 2'h0;
        nop_q[p] <= '0;
        dir_q[p] <= DPS_DIR_IDLE;
      end else begin
        if (acc[p]) begin
          idx_q[p] <= 2'h0;
          nop_q[p] <= load_nop[p];
        end else if (my_fire[p]) begin
          if (step_dec[p]) begin
            nop_q[p] <= nop_q[p] - 4'h1;
          end else if (step_turn[p]) begin
            nop_q[p] <= turn_nop[p];
          end else if (step_adv[p]) begin
            idx_q[p] <= idx_q[p] + 2'h1;
          end
        end
        if (my_fire[p]) begin
          dir_q[p] <= turn_dir[p];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      turn_q <= 1'b0;
    end else if (fire) begin
      turn_q <= ~turn_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fair_q <= 1'b0;
    end else if (coll_new) begin
      fair_q <= 1'b1;
    end else if (!act_d[1]) begin
      fair_q <= 1'b0;
    end
  end

  dps_slot_buf u_buf (
    .clk(clk),
    .rst(rst),
    .s(slot.buf_side)
  );

  // the output register reloads whenever it is empty or being emptied; the pop must follow the same condition
  assign slot.out_ready = !mem_valid || mem_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_valid <= 1'b0;
      mem_edge_fall <= 1'b0;
      mem_cmd <= DPS_CMD_NOP;
      mem_location <= '0;
    end else if (!mem_valid || mem_ready) begin
      mem_valid <= slot.out_valid;
      mem_edge_fall <= slot.out_slot.edge_fall;
      mem_cmd <= slot.out_slot.cmd;
      mem_location <= slot.out_slot.addr;
    end
  end
endmodule // dps_sched
`default_nettype wire

// file: dps_sched_props.sv
// port checker of the dual-port command scheduler
`include "dps_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dps_sched_props import dps_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic port_a_en,
  input wire logic port_a_ready,
  input wire logic port_b_en,
  input wire logic port_b_ready,
  input wire logic mem_valid,
  input wire logic mem_edge_fall,
  input wire dps_cmd_t mem_cmd,
  input wire logic [`DPS_ADDR_W-1:0] mem_location,
  input wire logic mem_ready
);
  logic seen_q;
  logic last_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // edge of the last slot taken, so alternation survives receiver stalls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_q <= 1'h0;
      last_q <= 1'h0;
    end else if (mem_valid && mem_ready) begin
      seen_q <= 1'h1;
      last_q <= mem_edge_fall;
    end
  end
  sequence s_take_a; port_a_en && port_a_ready; endsequence
  sequence s_take_b; port_b_en && port_b_ready; endsequence
  sequence s_b_back; ##[1:200] port_b_ready; endsequence
  property p_no_rsvd; mem_valid |-> mem_cmd != DPS_CMD_RSVD; endproperty
  a_no_rsvd: assert property (p_no_rsvd) else $error("reserved code on slot");
  property p_nop_zero; mem_valid && mem_cmd == DPS_CMD_NOP |-> mem_location == 21'h0; endproperty
  a_nop_zero: assert property (p_nop_zero) else $error("nop slot with location");
  property p_hold;
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_cmd) && $stable(mem_location) && $stable(mem_edge_fall);
  endproperty
  a_hold: assert property (p_hold) else $error("slot changed while stalled");
  property p_alt; mem_valid && mem_ready && seen_q |-> mem_edge_fall != last_q; endproperty
  a_alt: assert property (p_alt) else $error("slot edges do not alternate");
  property p_first; mem_valid && mem_ready && !seen_q |-> !mem_edge_fall; endproperty
  a_first: assert property (p_first) else $error("first slot not on rising edge");
  property p_a_busy; s_take_a |=> !port_a_ready; endproperty
  a_a_busy: assert property (p_a_busy) else $error("port a ready stayed high");
  property p_b_busy; s_take_b |=> !port_b_ready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("port b ready stayed high");
  property p_b_back; $fell(port_b_ready) |-> s_b_back; endproperty
  a_b_back: assert property (p_b_back) else $error("port b ready never returned");
endmodule // dps_sched_props
bind dps_sched dps_sched_props u_props (.clk(clk), .rst(rst), .port_a_en(port_a_en), .port_a_ready(port_a_ready),
  .port_b_en(port_b_en), .port_b_ready(port_b_ready), .mem_valid(mem_valid), .mem_edge_fall(mem_edge_fall),
  .mem_cmd(mem_cmd), .mem_location(mem_location), .mem_ready(mem_ready));
`default_nettype wire

// file: dps_sched_tb.sv
// testbench of the dual-port command scheduler
`timescale 1ns/1ps
`default_nettype none
module dps_sched_tb;
  import dps_pkg::*;
  logic clk, rst, port_a_en, port_b_en, port_a_ready, port_b_ready, stall;
  logic mem_valid, mem_edge_fall, mem_ready;
  dps_cmd_set_t port_a_cmd, port_b_cmd;
  dps_addr_set_t port_a_location, port_b_location;
  dps_cmd_t mem_cmd;
  logic [20:0] mem_location;
  int mismatches, checked;
  dps_slot_t exp_q[$];
  localparam dps_cmd_set_t RD4 = dps_cmd_set_t'({4{DPS_CMD_RD}});
  localparam dps_cmd_set_t WR4 = dps_cmd_set_t'({4{DPS_CMD_WR}});
  dps_sched DUT (.clk(clk), .rst(rst), .port_a_en(port_a_en), .port_a_cmd(port_a_cmd),
    .port_a_location(port_a_location), .port_a_ready(port_a_ready), .port_b_en(port_b_en),
    .port_b_cmd(port_b_cmd), .port_b_location(port_b_location), .port_b_ready(port_b_ready),
    .mem_valid(mem_valid), .mem_edge_fall(mem_edge_fall), .mem_cmd(mem_cmd),
    .mem_location(mem_location), .mem_ready(mem_ready));
  dps_mem_peer peer (.clk(clk), .rst(rst), .stall(stall), .mem_valid(mem_valid), .mem_edge_fall(mem_edge_fall),
    .mem_cmd(mem_cmd), .mem_location(mem_location), .mem_ready(mem_ready));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task wrap_up;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task note(input string what, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  function void put(input logic e, input dps_cmd_t c, input logic [20:0] l);
    exp_q.push_back({e, c, l});
  endfunction
  task reset_dut;
    @(posedge clk);
    rst <= 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask
  task offer(input logic ae, input logic be, input dps_cmd_set_t ac, input dps_cmd_set_t bc);
    port_a_en <= ae;
    port_b_en <= be;
    port_a_cmd <= ac;
    port_b_cmd <= bc;
    @(posedge clk);
  endtask
  // waits for both ports idle and the stream empty, then compares the slots
  task finish_set;
    int n;
    n = 0;
    while (n < 6) begin
      @(posedge clk);
      n = (port_a_ready === 1'h1 && port_b_ready === 1'h1 && mem_valid === 1'h0) ? n + 1 : 0;
    end
    note("slot count", 32'(exp_q.size()), 32'(peer.got.size()));
    foreach (exp_q[i]) note("slot", 32'(exp_q[i]), 32'(peer.got[i]));
    exp_q.delete();
  endtask
  task t_plain;
    reset_dut;
    stall <= 1'h1;
    offer(1'h1, 1'h1, RD4, dps_cmd_set_t'({DPS_CMD_RD, DPS_CMD_RD, DPS_CMD_RSVD, DPS_CMD_RD}));
    port_a_cmd <= WR4;
    port_b_cmd <= WR4;
    repeat (2) @(posedge clk);
    port_a_en <= 1'h0;
    port_b_en <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      put(1'h0, DPS_CMD_RD, port_a_location[i]);
      if (i == 1) put(1'h1, DPS_CMD_NOP, 21'h0);
      else put(1'h1, DPS_CMD_RD, port_b_location[i]);
    end
    finish_set;
  endtask
  task t_coll;
    reset_dut;
    stall <= 1'h0;
    port_b_location[0] <= {port_b_location[0][20:3], 3'h0};
    offer(1'h1, 1'h1, RD4, RD4);
    port_a_en <= 1'h0;
    port_b_en <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      put(1'h0, DPS_CMD_RD, port_a_location[i]);
      put(1'h1, DPS_CMD_NOP, 21'h0);
    end
    for (int i = 0; i < 4; i++) begin
      put(1'h0, DPS_CMD_NOP, 21'h0);
      put(1'h1, DPS_CMD_RD, port_b_location[i]);
    end
    finish_set;
  endtask
  task pa(input dps_cmd_t c, input logic [20:0] l, input int n);
    repeat (n) begin
      put(1'h0, c, l);
      put(1'h1, DPS_CMD_NOP, 21'h0);
    end
  endtask
  task t_turn;
    reset_dut;
    offer(1'h1, 1'h0, dps_cmd_set_t'({DPS_CMD_WR, DPS_CMD_RD, DPS_CMD_WR, DPS_CMD_RD}), RD4);
    port_a_en <= 1'h0;
    pa(DPS_CMD_RD, port_a_location[0], 1);
    pa(DPS_CMD_NOP, 21'h0, 8);
    pa(DPS_CMD_WR, port_a_location[1], 1);
    pa(DPS_CMD_NOP, 21'h0, 4);
    pa(DPS_CMD_RD, port_a_location[2], 1);
    pa(DPS_CMD_NOP, 21'h0, 8);
    // the stream stops once the last busy port is done, so no partner slot follows
    put(1'h0, DPS_CMD_WR, port_a_location[3]);
    finish_set;
  endtask
  // B collides on lane 0, then A's next write set hits B's held bank while B is still busy
  task t_fair;
    reset_dut;
    stall <= 1'h0;
    offer(1'h1, 1'h1, RD4, RD4);
    port_a_cmd <= WR4;
    port_b_en <= 1'h0;
    repeat (8) @(posedge clk);
    port_a_en <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      put(1'h0, DPS_CMD_RD, port_a_location[i]);
      put(1'h1, DPS_CMD_NOP, 21'h0);
    end
    for (int i = 0; i < 4; i++) begin
      put(1'h0, DPS_CMD_NOP, 21'h0);
      put(1'h1, DPS_CMD_RD, port_b_location[i]);
    end
    pa(DPS_CMD_NOP, 21'h0, 8);
    for (int i = 0; i < 4; i++) begin
      put(1'h0, DPS_CMD_WR, port_a_location[i]);
      if (i < 3) put(1'h1, DPS_CMD_NOP, 21'h0);
    end
    finish_set;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
  initial begin
    // lane i of A uses bank i; B uses bank (i+7) mod 8, so B lane 1 meets A lane 0 only across lanes
    for (int i = 0; i < 4; i++) begin
      port_a_location[i] = 21'(21'h1000 * (i + 1) + i);
      port_b_location[i] = 21'(21'h2_0000 + 21'h1000 * i + ((i + 7) % 8));
    end
    rst = 1'h1;
    stall = 1'h0;
    port_a_en = 1'h0;
    port_b_en = 1'h0;
    port_a_cmd = RD4;
    port_b_cmd = RD4;
    t_plain;
    t_coll;
    t_turn;
    t_fair;
    wrap_up;
  end
endmodule // dps_sched_tb
`default_nettype wire

// file: dps_slot_buf.sv
// two-entry slot buffer with registered outputs
`timescale 1ns/1ps
`default_nettype none
module dps_slot_buf (
  input wire logic clk,
  input wire logic rst,
  dps_slot_if.buf_side s
);
  import dps_pkg::*;
  dps_slot_t ent_q [2];
  logic [1:0] cnt_q;
  logic push;
  logic pop;

  assign push = s.in_valid && s.in_ready;
  assign pop = s.out_valid && s.out_ready;
  // ready depends on the count alone, never on the receiver in the same cycle; the second entry absorbs a stall
  assign s.in_ready = (cnt_q != 2'h2);
  assign s.out_valid = (cnt_q != 2'h0);
  assign s.out_slot = ent_q[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ent_q[0] <= '0;
      ent_q[1] <= '0;
    end else begin
      if (pop) begin
        ent_q[0] <= (cnt_q == 2'h2) ? ent_q[1] : s.in_slot;
        if (push && cnt_q == 2'h2) begin
          ent_q[1] <= s.in_slot;
        end
      end else if (push) begin
        if (cnt_q == 2'h0) begin
          ent_q[0] <= s.in_slot;
        end else begin
          ent_q[1] <= s.in_slot;
        end
      end
    end
  end
endmodule // dps_slot_buf
`default_nettype wire

// file: dps_slot_if.sv
// slot stream between scheduler and output buffer
`timescale 1ns/1ps
`default_nettype none
interface dps_slot_if;
  import dps_pkg::*;
  logic in_valid;
  logic in_ready;
  dps_slot_t in_slot;
  logic out_valid;
  logic out_ready;
  dps_slot_t out_slot;
  modport sched (output in_valid, output in_slot, input in_ready);
  modport buf_side (input in_valid, input in_slot, output in_ready,
                    output out_valid, output out_slot, input out_ready);
endinterface
`default_nettype wire
